// ===== inc/gpio_port_pkg.sv
// package for the four-port general-purpose i/o block
package gpio_port_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam logic [7:0] PORT_A_DATA_ADDR = 8'h12;
	localparam logic [7:0] PORT_A_DIRECTION_ADDR = 8'h13;
	localparam logic [7:0] PORT_B_DATA_ADDR = 8'h14;
	localparam logic [7:0] PORT_B_DIRECTION_ADDR = 8'h15;
	localparam logic [7:0] PORT_C_DATA_ADDR = 8'h16;
	localparam logic [7:0] PORT_C_DIRECTION_ADDR = 8'h17;
	localparam logic [7:0] PORT_F_DATA_ADDR = 8'h1c;
	localparam logic [7:0] PORT_F_DIRECTION_ADDR = 8'h1d;
	localparam int unsigned LINE_COUNT = 23;
	localparam int unsigned PORT_A_LSB = 0;
	localparam int unsigned PORT_B_LSB = 8;
	localparam int unsigned PORT_C_LSB = 16;
	localparam int unsigned PORT_F_LSB = 22;
	localparam logic [7:0] PORT_A_MASK = 8'hff;
	localparam logic [7:0] PORT_B_MASK = 8'hff;
	localparam logic [7:0] PORT_C_MASK = 8'h3f;
	localparam logic [7:0] PORT_F_MASK = 8'h01;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] DIRECTION_RESET = 8'hff;
	localparam int unsigned SYNC_STAGES = 3;
	localparam logic [2:0] SETTLE_CYCLES = 3'h5;

	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_READ = 2'b01,
		OP_WRITE = 2'b10
	} bus_op_t;

	typedef struct packed {
		logic portAPullHigh;
		logic portBLowPullHigh;
		logic portBHighPullHigh;
		logic portCPullHigh;
		logic portFPullHigh;
		logic freqDividerSelect;
		logic [7:0] portAWakeEnable;
	} port_options_t;

	typedef struct packed {
		logic [LINE_COUNT-1:0] out;
		logic [LINE_COUNT-1:0] oe;
		logic [LINE_COUNT-1:0] pullHigh;
	} pad_drive_t;
endpackage : gpio_port_pkg

// ===== core/pad_sync.sv
// three-stage pad synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pad_sync
	import gpio_port_pkg::*;
#(
	parameter int unsigned WIDTH = LINE_COUNT
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// pad levels in, filtered levels out
	input wire logic [WIDTH-1:0] padRaw,
	output logic [WIDTH-1:0] padStable
);
	logic [WIDTH-1:0] stage1_q;
	logic [WIDTH-1:0] stage2_q;
	logic [WIDTH-1:0] stage3_q;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk_sys) begin
				if (!rst_n) begin
					stage1_q[i] <= 1'b0;
					stage2_q[i] <= 1'b0;
					stage3_q[i] <= 1'b0;
					padStable[i] <= 1'b0;
				end else begin
					stage1_q[i] <= padRaw[i];
					stage2_q[i] <= stage1_q[i];
					stage3_q[i] <= stage2_q[i];
					// change accepted once stages two and three agree
					if (stage2_q[i] == stage3_q[i]) begin
						padStable[i] <= stage3_q[i];
					end
				end
			end
		end
	endgenerate
endmodule : pad_sync
`default_nettype wire

// ===== core/bidir_io_port_block.sv
// four bidirectional general-purpose ports with data-memory mapped registers
//
// Functional notes
// - 23 bidirectional lines in four ports
// - data latches at 12H 14H 16H 1CH
// - inputs unlatched, sampled at read time
// - output latch holds until next write
// - per-line direction bit, 1 is input
// - direction registers at 13H 15H 17H 1DH
// - read returns pad for inputs, latch otherwise
// - read-modify-write uses same source selection
// - bit operations read, modify, write back
// - pull-high connects automatically on inputs
// - after reset all lines are inputs
// - each port A line can wake device
// - missing port C and F bits read zero
// - divider output gated by port B bit zero
// - port B bit zero input unaffected by divider
// - shared external interrupt and timer count pins
// - pull-high options per port, port B halves
`timescale 1ns/1ps
`default_nettype none
module bidir_io_port_block
	import gpio_port_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// core data-memory access
	input wire logic [ADDR_W-1:0] memAddr,
	input wire logic memRead,
	input wire logic memWrite,
	input wire logic [DATA_W-1:0] memWrData,
	output logic [DATA_W-1:0] memRdData,
	output logic memRdHit,
	// option straps, divider source and halt status
	input wire port_options_t options,
	input wire logic freqDividerIn,
	input wire logic haltActive,
	// pads
	input wire logic [LINE_COUNT-1:0] padIn,
	output logic [LINE_COUNT-1:0] padOut,
	output logic [LINE_COUNT-1:0] padOe,
	output logic [LINE_COUNT-1:0] padPullHigh,
	// shared-pin functions
	output logic externalIrqIn_n,
	output logic timer0CountIn,
	output logic wakeRequest
);
	logic [7:0] portAData_q;
	logic [7:0] portBData_q;
	logic [7:0] portCData_q;
	logic [7:0] portFData_q;
	logic [7:0] portADir_q;
	logic [7:0] portBDir_q;
	logic [7:0] portCDir_q;
	logic [7:0] portFDir_q;
	logic [LINE_COUNT-1:0] padSync;
	logic [LINE_COUNT-1:0] latchAll;
	logic [LINE_COUNT-1:0] dirAll;
	logic [LINE_COUNT-1:0] readAll;
	logic [LINE_COUNT-1:0] pullOpt;
	logic [LINE_COUNT-1:0] outNext;
	logic [7:0] portAWakePrev_q;
	logic [7:0] rdData_d;
	logic rdHit_d;
	bus_op_t busOp;
	logic [7:0] portAWake;
	logic [7:0] wrSel;
	logic [2:0] settleCount_q;
	logic settled;

	// pad inputs cross into the system clock
	pad_sync #(
		.WIDTH(LINE_COUNT)
	) u_pad_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.padRaw(padIn),
		.padStable(padSync)
	);

	assign latchAll = {portFData_q[0], portCData_q[5:0], portBData_q, portAData_q};
	assign dirAll = {portFDir_q[0], portCDir_q[5:0], portBDir_q, portADir_q};

	// per-line read source: pad for inputs, latch for outputs
	genvar i;
	generate
		for (i = 0; i < LINE_COUNT; i++) begin : g_line
			assign readAll[i] = dirAll[i] ? padSync[i] : latchAll[i];
		end
	endgenerate

	assign busOp = memWrite ? OP_WRITE : (memRead ? OP_READ : OP_NONE);

	// one write strobe per register
	always_comb begin
		wrSel = 8'h00;
		if (busOp == OP_WRITE) begin
			case (memAddr)
				PORT_A_DATA_ADDR: begin
					wrSel[0] = 1'b1;
				end
				PORT_B_DATA_ADDR: begin
					wrSel[1] = 1'b1;
				end
				PORT_C_DATA_ADDR: begin
					wrSel[2] = 1'b1;
				end
				PORT_F_DATA_ADDR: begin
					wrSel[3] = 1'b1;
				end
				PORT_A_DIRECTION_ADDR: begin
					wrSel[4] = 1'b1;
				end
				PORT_B_DIRECTION_ADDR: begin
					wrSel[5] = 1'b1;
				end
				PORT_C_DIRECTION_ADDR: begin
					wrSel[6] = 1'b1;
				end
				PORT_F_DIRECTION_ADDR: begin
					wrSel[7] = 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// shared-pin outputs stay idle until the synchroniser has flushed
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			settleCount_q <= 3'h0;
		end else if (settleCount_q != SETTLE_CYCLES) begin
			settleCount_q <= settleCount_q + 3'h1;
		end
	end

	assign settled = (settleCount_q == SETTLE_CYCLES);

	// data latches, written only by the core
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			portAData_q <= DATA_RESET;
			portBData_q <= DATA_RESET;
			portCData_q <= DATA_RESET;
			portFData_q <= DATA_RESET;
		end else begin
			// bit operations arrive here as full-port write-back
			if (wrSel[0]) begin
				portAData_q <= memWrData & PORT_A_MASK;
			end
			if (wrSel[1]) begin
				portBData_q <= memWrData & PORT_B_MASK;
			end
			if (wrSel[2]) begin
				portCData_q <= memWrData & PORT_C_MASK;
			end
			if (wrSel[3]) begin
				portFData_q <= memWrData & PORT_F_MASK;
			end
		end
	end

	// direction registers, all inputs after reset
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			portADir_q <= DIRECTION_RESET & PORT_A_MASK;
			portBDir_q <= DIRECTION_RESET & PORT_B_MASK;
			portCDir_q <= DIRECTION_RESET & PORT_C_MASK;
			portFDir_q <= DIRECTION_RESET & PORT_F_MASK;
		end else begin
			if (wrSel[4]) begin
				portADir_q <= memWrData & PORT_A_MASK;
			end
			if (wrSel[5]) begin
				portBDir_q <= memWrData & PORT_B_MASK;
			end
			if (wrSel[6]) begin
				portCDir_q <= memWrData & PORT_C_MASK;
			end
			if (wrSel[7]) begin
				portFDir_q <= memWrData & PORT_F_MASK;
			end
		end
	end

	// read mux
	always_comb begin
		rdData_d = 8'h00;
		rdHit_d = 1'b1;
		case (memAddr)
			PORT_A_DATA_ADDR: begin
				rdData_d = readAll[PORT_A_LSB +: 8];
			end
			PORT_B_DATA_ADDR: begin
				rdData_d = readAll[PORT_B_LSB +: 8];
			end
			PORT_C_DATA_ADDR: begin
				rdData_d = {2'b00, readAll[PORT_C_LSB +: 6]};
			end
			PORT_F_DATA_ADDR: begin
				rdData_d = {7'h00, readAll[PORT_F_LSB]};
			end
			PORT_A_DIRECTION_ADDR: begin
				rdData_d = portADir_q;
			end
			PORT_B_DIRECTION_ADDR: begin
				rdData_d = portBDir_q;
			end
			PORT_C_DIRECTION_ADDR: begin
				rdData_d = portCDir_q & PORT_C_MASK;
			end
			PORT_F_DIRECTION_ADDR: begin
				rdData_d = portFDir_q & PORT_F_MASK;
			end
			default: begin
				rdHit_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			memRdData <= 8'h00;
			memRdHit <= 1'b0;
		end else if (busOp == OP_READ) begin
			memRdData <= rdData_d;
			memRdHit <= rdHit_d;
		end else begin
			memRdData <= 8'h00;
			memRdHit <= 1'b0;
		end
	end

	// pull-high option map
	assign pullOpt = {options.portFPullHigh, {6{options.portCPullHigh}},
		{4{options.portBHighPullHigh}}, {4{options.portBLowPullHigh}},
		{8{options.portAPullHigh}}};

	// output value with divider on port B bit zero
	always_comb begin
		outNext = latchAll;
		if (options.freqDividerSelect) begin
			outNext[PORT_B_LSB] = portBData_q[0] & freqDividerIn;
		end
	end

	// pad drive, one slice per line
	generate
		for (i = 0; i < LINE_COUNT; i++) begin : g_drive
			always_ff @(posedge clk_sys) begin
				if (!rst_n) begin
					padOut[i] <= 1'b0;
					padOe[i] <= 1'b0;
					padPullHigh[i] <= 1'b0;
				end else begin
					padOut[i] <= outNext[i];
					padOe[i] <= ~dirAll[i];
					padPullHigh[i] <= pullOpt[i] & dirAll[i];
				end
			end
		end
	endgenerate

	// shared-pin functions
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			externalIrqIn_n <= 1'b1;
			timer0CountIn <= 1'b0;
		end else if (settled) begin
			externalIrqIn_n <= padSync[PORT_F_LSB];
			timer0CountIn <= padSync[PORT_C_LSB];
		end
	end

	// port A wake, one change detector per line
	generate
		for (i = 0; i < 8; i++) begin : g_wake
			assign portAWake[i] = (padSync[PORT_A_LSB + i] ^ portAWakePrev_q[i]) & options.portAWakeEnable[i]
				& portADir_q[i];
			always_ff @(posedge clk_sys) begin
				if (!rst_n) begin
					portAWakePrev_q[i] <= 1'b0;
				end else begin
					portAWakePrev_q[i] <= padSync[PORT_A_LSB + i];
				end
			end
		end
	endgenerate

	// wake only while halted
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wakeRequest <= 1'b0;
		end else begin
			wakeRequest <= settled & haltActive & (|portAWake);
		end
	end
endmodule : bidir_io_port_block
`default_nettype wire

// ===== verification/bidir_io_port_block_sva.sv
// assertions on the port block boundary
`timescale 1ns/1ps
`default_nettype none
module bidir_io_port_block_sva
	import gpio_port_pkg::*;
(
	// block ports
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] memAddr,
	input wire logic memRead,
	input wire logic memWrite,
	input wire logic [DATA_W-1:0] memWrData,
	input wire logic [DATA_W-1:0] memRdData,
	input wire logic memRdHit,
	input wire port_options_t options,
	input wire logic freqDividerIn,
	input wire logic haltActive,
	input wire logic [LINE_COUNT-1:0] padIn,
	input wire logic [LINE_COUNT-1:0] padOut,
	input wire logic [LINE_COUNT-1:0] padOe,
	input wire logic [LINE_COUNT-1:0] padPullHigh,
	input wire logic externalIrqIn_n,
	input wire logic timer0CountIn,
	input wire logic wakeRequest
);
	logic rdOnly;
	logic wrA;
	logic mapped;
	assign rdOnly = memRead && !memWrite;
	assign wrA = memWrite && memAddr == PORT_A_DATA_ADDR;
	assign mapped = (memAddr >= 8'h12 && memAddr <= 8'h17) || memAddr[7:1] == 7'h0e;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_reset_inputs: assert property ($rose(rst_n) |-> padOe == '0 [*2])
		else $error("lines not inputs after reset");
	a_unmapped_read: assert property (rdOnly && !mapped |=> memRdData == '0 && !memRdHit)
		else $error("unmapped read answered");
	a_mapped_hit: assert property (rdOnly && mapped |=> memRdHit)
		else $error("register read missed");
	a_missing_bits: assert property (rdOnly && memAddr >= 8'h16 |=>
		!(|memRdData[7:6]) && ($past(memAddr) < 8'h1c || !(|memRdData[7:1])))
		else $error("missing bits read nonzero");
	a_pull_input: assert property ((padOe & padPullHigh) == '0)
		else $error("pull on driven line");
	a_dir_to_oe: assert property (memWrite && memAddr == PORT_A_DIRECTION_ADDR ##1 !memWrite
		|=> padOe[7:0] == ~$past(memWrData, 2))
		else $error("direction not applied");
	a_latch_hold: assert property (!wrA |-> ##2 $stable(padOut[7:0]))
		else $error("latch changed without write");
	a_divider_gate: assert property (options.freqDividerSelect && padOe[8] && !$past(freqDividerIn)
		|-> !padOut[8])
		else $error("divider output not gated");
	a_wake_halt: assert property (!haltActive |=> !wakeRequest)
		else $error("wake outside halt");
	c_read_hit: cover property (rdOnly && mapped ##1 memRdHit);
	c_divider: cover property (padOe[8] && padOut[8]);
	c_wake: cover property (wakeRequest);
endmodule : bidir_io_port_block_sva
bind bidir_io_port_block bidir_io_port_block_sva i_bidir_io_port_block_sva (.clk_sys, .rst_n,
	.memAddr, .memRead, .memWrite, .memWrData, .memRdData, .memRdHit, .options, .freqDividerIn,
	.haltActive, .padIn, .padOut, .padOe, .padPullHigh, .externalIrqIn_n, .timer0CountIn, .wakeRequest);
`default_nettype wire

// ===== verification/pad_model.sv
// board-side pin model for the port block
`timescale 1ns/1ps
`default_nettype none
module pad_model
	import gpio_port_pkg::*;
(
	// clock
	input wire logic clk_sys,
	// block and board drivers
	input wire logic [LINE_COUNT-1:0] padOut,
	input wire logic [LINE_COUNT-1:0] padOe,
	input wire logic [LINE_COUNT-1:0] padPullHigh,
	input wire logic [LINE_COUNT-1:0] extVal,
	input wire logic [LINE_COUNT-1:0] extEn,
	// resolved level
	output logic [LINE_COUNT-1:0] padIn
);
	logic [LINE_COUNT-1:0] noise = '0;
	// floating lines wander
	always @(posedge clk_sys) noise <= ~noise;
	assign padIn = (padOe & padOut) | (~padOe & extEn & extVal) | (~padOe & ~extEn & (padPullHigh | noise));
endmodule : pad_model
`default_nettype wire

// ===== verification/bidir_io_port_block_test.sv
// self-checking bench for the port block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; $display("mismatch %0t %h", $time, a); end end
module bidir_io_port_block_test
	import gpio_port_pkg::*;
;
	logic clk_sys = 0, rst_n = 0, memRead = 0, memWrite = 0, freqDividerIn = 0, haltActive = 0;
	logic [7:0] memAddr = '0, memWrData = '0, memRdData;
	logic [8:0] rdv;
	port_options_t options = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 8'hff};
	logic [LINE_COUNT-1:0] extVal = '0, extEn = '0, padIn, padOut, padOe, padPullHigh;
	logic memRdHit, externalIrqIn_n, timer0CountIn, wakeRequest;
	int n_fail = 0;
	int check_count = 0;
	always #2.5 clk_sys = ~clk_sys;
	bidir_io_port_block i_bidir_io_port_block (.clk_sys, .rst_n, .memAddr, .memRead, .memWrite,
		.memWrData, .memRdData, .memRdHit, .options, .freqDividerIn, .haltActive, .padIn, .padOut,
		.padOe, .padPullHigh, .externalIrqIn_n, .timer0CountIn, .wakeRequest);
	pad_model i_pad_model (.clk_sys, .padOut, .padOe, .padPullHigh, .extVal, .extEn, .padIn);
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		memAddr <= a;
		memWrData <= d;
		memWrite <= 1'b1;
		@(posedge clk_sys);
		memWrite <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		memAddr <= a;
		memRead <= 1'b1;
		@(posedge clk_sys);
		memRead <= 1'b0;
		#1;
		rdv = {memRdHit, memRdData};
	endtask : rd
	task automatic wrap_up;
		if (n_fail == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : wrap_up
	initial begin
		int i;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
		`CHK(padOe, '0)
		`CHK(padPullHigh[15:8], 8'h0f)
		rd(PORT_A_DATA_ADDR);
		`CHK(rdv, 9'h1ff)
		rd(PORT_C_DIRECTION_ADDR);
		`CHK(rdv, 9'h13f)
		rd(PORT_F_DIRECTION_ADDR);
		`CHK(rdv, 9'h101)
		rd(8'h18);
		`CHK(rdv, 9'h000)
		wr(PORT_A_DATA_ADDR, 8'ha5);
		wr(PORT_A_DIRECTION_ADDR, 8'hf0);
		extVal[7:4] <= 4'h3;
		extEn[7:4] <= 4'hf;
		repeat (6) @(posedge clk_sys);
		`CHK({padOe[7:0], padOut[3:0]}, 12'h0f5)
		rd(PORT_A_DATA_ADDR);
		`CHK(rdv, 9'h135)
		wr(PORT_A_DATA_ADDR, rdv[7:0] | 8'h02);
		wr(PORT_A_DIRECTION_ADDR, 8'h00);
		rd(PORT_A_DATA_ADDR);
		`CHK(rdv, 9'h137)
		wr(PORT_C_DATA_ADDR, 8'hff);
		wr(PORT_C_DIRECTION_ADDR, 8'h00);
		rd(PORT_C_DATA_ADDR);
		`CHK(rdv, 9'h13f)
		wr(PORT_B_DIRECTION_ADDR, 8'hfe);
		for (i = 0; i < 4; i++) begin
			wr(PORT_B_DATA_ADDR, {7'h00, i[1]});
			freqDividerIn <= i[0];
			repeat (3) @(posedge clk_sys);
			#1;
			`CHK(padOut[8], i[1] & i[0])
		end
		wr(PORT_B_DIRECTION_ADDR, 8'h01);
		extEn[8] <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rd(PORT_B_DATA_ADDR);
		`CHK(rdv, 9'h100)
		extEn[22] <= 1'b1;
		repeat (6) @(posedge clk_sys);
		`CHK({externalIrqIn_n, timer0CountIn}, 2'b01)
		wr(PORT_A_DIRECTION_ADDR, 8'hff);
		repeat (6) @(posedge clk_sys);
		haltActive <= 1'b1;
		repeat (2) @(posedge clk_sys);
		extEn[0] <= 1'b1;
		for (i = 0; i < 20 && wakeRequest !== 1'b1; i++) @(posedge clk_sys);
		`CHK(wakeRequest, 1'b1)
		wrap_up();
	end
endmodule : bidir_io_port_block_test
`default_nettype wire
